// >>> shared/lbus_ctl_consts.vh
`ifndef LBUS_CTL_CONSTS_VH
`define LBUS_CTL_CONSTS_VH
// Region width codes on i_region_width
`define WIDTH_8           2'h0
`define WIDTH_16          2'h1
`define WIDTH_32          2'h2
// Source of an access on i_req_src
`define SRC_CORE          2'h0
`define SRC_DMA           2'h1
`define SRC_ATU           2'h2
// Transfer FIFO shape
`define XFER_FIFO_DEPTH   8
`define XFER_FIFO_AW      3
`define XFER_FIFO_WIDTH   8
// Fields of one FIFO word: byte enables (active high) in 3:0, last flag in 4
`define XW_BE_LSB         0
`define XW_BE_MSB         3
`define XW_LAST           4
// Bus state codes
`define ST_IDLE           3'h0
`define ST_ADDR           3'h1
`define ST_DATA           3'h2
`define ST_RECOV          3'h3
`define ST_HOLD           3'h4
// Reset values of active-low outputs
`define BE_IDLE_N         4'hf
`endif

// >>> hw/xfer_fifo.v
`timescale 1ns/1ps
`include "lbus_ctl_consts.vh"
module xfer_fifo #(
  parameter WIDTH = `XFER_FIFO_WIDTH,
  parameter DEPTH = `XFER_FIFO_DEPTH,
  parameter AW    = `XFER_FIFO_AW
) (
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire             i_ce,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  // Full and empty from an occupancy count
  assign o_in_ready  = (count_r != DEPTH[AW:0]);
  assign o_out_valid = (count_r != {(AW+1){1'b0}});
  assign o_out_data  = mem_r[rd_ptr_r];
  assign push        = i_ce & i_in_valid & o_in_ready;
  assign pop         = i_ce & o_out_valid & i_out_ready;

  // Storage needs no reset; only pointers and count do
  always @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // Pointers and count
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// >>> hw/strap_sampler.v
`timescale 1ns/1ps
`include "lbus_ctl_consts.vh"
module strap_sampler (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_ce,
  input  wire i_pci_rst_n,
  input  wire i_core_hold_strap,
  input  wire i_float_all_mode_n,
  input  wire i_bus_width_retry_strap,
  input  wire i_core_reset_clear,
  output reg  o_core_in_reset,
  output reg  o_float_all,
  output reg  o_periph_via_secondary
);
  reg pci_rst_d_r;
  reg hold_strap_r;
  reg float_strap_r;

  // Core-hold and float straps follow the pins while PCI reset is low, then freeze at release; the width/retry strap is followed every clock
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pci_rst_d_r            <= 1'b0;
      hold_strap_r           <= 1'b1;
      float_strap_r          <= 1'b1;
      o_core_in_reset        <= 1'b1;
      o_float_all            <= 1'b0;
      o_periph_via_secondary <= 1'b0;
    end else if (i_ce) begin
      pci_rst_d_r <= i_pci_rst_n;
      if (!i_pci_rst_n) begin
        hold_strap_r    <= i_core_hold_strap;
        float_strap_r   <= i_float_all_mode_n;
        o_core_in_reset <= 1'b1;
        o_float_all     <= 1'b0;
      end else if (!pci_rst_d_r) begin
        o_core_in_reset <= ~hold_strap_r;
        o_float_all     <= ~float_strap_r;
      end else if (i_core_reset_clear) begin
        o_core_in_reset <= 1'b0;
      end
      o_periph_via_secondary <= i_bus_width_retry_strap;
    end
  end
endmodule

// >>> hw/local_bus_master_control.v
// Operation
// - 32-bit region: select 3..0 enable bytes 31:24, 23:16, 15:8, 7:0.
// - 16-bit region: sel3 high byte, sel0 low byte, sel2 high, sel1 A1.
// - 8-bit region: sel3 and sel2 high, sel1 is A1, sel0 is A0.
// - Address bits on selects increment on each internal or external ready.
// - Selects asserted in address cycle and held through last data cycle.
// - Core bursts on 32-bit keep selects fixed; DMA and ADDRESS_TRANSLATION_UNIT change per transfer.
// - Data strobe low from first data cycle start to last data cycle end.
// - Direction low for reads, high for writes, through address to data.
// - Direction never changes while data strobe is asserted.
// - Data-or-code low for fetch, high for data, timed like write-not-read.
// - Core-hold strap sampled in PCI reset decides core start or held reset.
// - Held core: peripherals reachable from PCI bus chosen by width/retry strap.
// - Lock low in first clock of atomic operation, released on last transfer.
// - No hold acknowledge granted while lock is asserted.
// - Float strap low at reset end stops clocks and floats all outputs.
// - Local ready/recover output copies the ready/recover function; the code copies it in data cycles only and drives it high in recovery.
// - Ready/recover high in data cycle inserts one wait clock.
// - Recovery states repeat until ready/recover samples high.
// - Write-not-read valid in address cycle and latched through data cycles.
// - Granted hold: assert acknowledge, float bus until request drops.
`timescale 1ns/1ps
`include "lbus_ctl_consts.vh"
module local_bus_master_control (
  input  wire       i_sys_clk,
  input  wire       i_resetn,
  input  wire       i_ce,
  // Request side, one beat per FIFO word
  input  wire       i_beat_valid,
  output reg        o_beat_ready,
  input  wire [3:0] i_beat_be,
  input  wire       i_beat_last,
  input  wire [1:0] i_region_width,
  input  wire [1:0] i_req_src,
  input  wire [1:0] i_start_addr,
  input  wire       i_req_write,
  input  wire       i_req_data,
  input  wire       i_req_atomic,
  input  wire       i_int_mem_ctl,
  input  wire       i_internal_ready_n,
  input  wire       i_ext_ready_recover_n,
  input  wire       i_hold_req,
  input  wire       i_pci_rst_n,
  input  wire       i_core_hold_strap,
  input  wire       i_float_all_mode_n,
  input  wire       i_bus_width_retry_strap,
  input  wire       i_core_reset_clear,
  output reg  [3:0] o_byte_lane_sel_n,
  output reg        o_byte_lane_sel_oe,
  output reg        o_data_phase_strobe_n,
  output reg        o_xfer_direction,
  output reg        o_write_not_read,
  output reg        o_data_not_code,
  output reg        o_lock_n,
  output reg        o_ctl_oe,
  output reg        o_bus_hold_ack,
  output reg        o_local_ready_recover_out_n,
  output reg        o_core_in_reset,
  output reg        o_clocks_stopped,
  output reg        o_periph_via_secondary,
  output reg        o_access_done
);
  reg        rst_s1_r;
  reg        rst_s2_r;
  wire       rst_n;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [1:0] width_r;
  reg  [1:0] src_r;
  reg  [1:0] addr_r;
  reg  [3:0] be_r;
  reg        last_r;
  wire       start;
  wire       take;
  wire [1:0] width_nxt;
  wire [1:0] addr_nxt;
  wire [3:0] be_nxt;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [7:0] fifo_in_data;
  wire [3:0] head_be;
  wire       head_last;
  wire       ready_n;
  wire       beat_ok;
  wire       float_all;
  wire       core_rst;
  wire       via_sec;
  wire       run;
  reg  [3:0] sel_n;

  // Reset release through two flops
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // Beats queue ahead of the bus so requesters are not stalled per wait state
  assign fifo_in_data = {3'h0, i_beat_last, i_beat_be};
  xfer_fifo #(
    .WIDTH (`XFER_FIFO_WIDTH),
    .DEPTH (`XFER_FIFO_DEPTH),
    .AW    (`XFER_FIFO_AW)
  ) u_fifo (
    .i_clk       (i_sys_clk),
    .i_rst_n     (rst_n),
    .i_ce        (run),
    .i_in_valid  (i_beat_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (take),
    .o_out_data  (fifo_out_data)
  );

  strap_sampler u_straps (
    .i_clk                   (i_sys_clk),
    .i_rst_n                 (rst_n),
    .i_ce                    (i_ce),
    .i_pci_rst_n             (i_pci_rst_n),
    .i_core_hold_strap       (i_core_hold_strap),
    .i_float_all_mode_n      (i_float_all_mode_n),
    .i_bus_width_retry_strap (i_bus_width_retry_strap),
    .i_core_reset_clear      (i_core_reset_clear),
    .o_core_in_reset         (core_rst),
    .o_float_all             (float_all),
    .o_periph_via_secondary  (via_sec)
  );

  assign run       = i_ce & ~float_all;
  assign head_be   = fifo_out_data[`XW_BE_MSB:`XW_BE_LSB];
  assign head_last = fifo_out_data[`XW_LAST];
  // The ready source picked by i_int_mem_ctl ends a beat
  assign ready_n   = i_int_mem_ctl ? i_internal_ready_n : i_ext_ready_recover_n;
  // No ready means a wait clock; a middle beat also waits for its successor
  assign beat_ok   = (state_r == `ST_DATA) & ~ready_n & (last_r | fifo_out_valid);
  // Each word leaves the FIFO as its beat begins, so the next one is already at the head
  assign start     = (state_r == `ST_IDLE) & (state_nxt == `ST_ADDR);
  assign take      = start | (beat_ok & ~last_r);
  assign width_nxt = start ? i_region_width : width_r;
  assign addr_nxt  = start ? i_start_addr : (beat_ok ? addr_r + 2'h1 : addr_r);
  // DMA and ADDRESS_TRANSLATION_UNIT retarget lanes per beat; core keeps the first
  assign be_nxt    = (start | (beat_ok & ~last_r & (src_r != `SRC_CORE))) ? head_be : be_r;

  // Lane decode from next-cycle context, so registered lanes line up with their beat
  always @* begin
    sel_n = `BE_IDLE_N;
    case (width_nxt)
      `WIDTH_32: begin
        sel_n = ~be_nxt;
      end
      `WIDTH_16: begin
        sel_n = {~(be_nxt[3] | be_nxt[1]), 1'b1, addr_nxt[1], ~(be_nxt[2] | be_nxt[0])};
      end
      `WIDTH_8: begin
        sel_n = {2'h3, addr_nxt[1], addr_nxt[0]};
      end
      default: begin
        sel_n = `BE_IDLE_N;
      end
    endcase
  end

  // Bus sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_IDLE: begin
        if (i_hold_req & o_lock_n) begin
          state_nxt = `ST_HOLD;
        end else if (fifo_out_valid & ~core_rst) begin
          state_nxt = `ST_ADDR;
        end
      end
      `ST_ADDR: begin
        state_nxt = `ST_DATA;
      end
      `ST_DATA: begin
        if (beat_ok & last_r) begin
          state_nxt = `ST_RECOV;
        end
      end
      `ST_RECOV: begin
        if (i_ext_ready_recover_n | i_int_mem_ctl) begin
          state_nxt = `ST_IDLE;
        end
      end
      `ST_HOLD: begin
        if (!i_hold_req) begin
          state_nxt = `ST_IDLE;
        end
      end
      default: begin
        state_nxt = `ST_IDLE;
      end
    endcase
  end

  // Registered outputs and access context
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r                     <= `ST_IDLE;
      width_r                     <= `WIDTH_32;
      src_r                       <= `SRC_CORE;
      addr_r                      <= 2'h0;
      be_r                        <= 4'h0;
      last_r                      <= 1'b0;
      o_beat_ready                <= 1'b0;
      o_byte_lane_sel_n           <= `BE_IDLE_N;
      o_byte_lane_sel_oe          <= 1'b0;
      o_data_phase_strobe_n       <= 1'b1;
      o_xfer_direction            <= 1'b0;
      o_write_not_read            <= 1'b0;
      o_data_not_code             <= 1'b1;
      o_lock_n                    <= 1'b1;
      o_ctl_oe                    <= 1'b0;
      o_bus_hold_ack              <= 1'b0;
      o_local_ready_recover_out_n <= 1'b1;
      o_core_in_reset             <= 1'b1;
      o_clocks_stopped            <= 1'b0;
      o_periph_via_secondary      <= 1'b0;
      o_access_done               <= 1'b0;
    end else if (run) begin
      state_r                <= state_nxt;
      o_beat_ready           <= fifo_in_ready;
      o_core_in_reset        <= core_rst;
      o_periph_via_secondary <= via_sec;
      o_access_done          <= (state_r == `ST_DATA) & (state_nxt == `ST_RECOV);
      o_bus_hold_ack         <= (state_nxt == `ST_HOLD);
      o_ctl_oe               <= (state_nxt != `ST_HOLD);
      o_byte_lane_sel_oe     <= (state_nxt != `ST_HOLD);
      o_local_ready_recover_out_n <= (state_r == `ST_DATA) ? ready_n :
                                     (state_r == `ST_RECOV) ? 1'b1 : 1'b1;
      width_r <= width_nxt;
      addr_r  <= addr_nxt;
      be_r    <= be_nxt;
      // Current beat's last flag travels with the word just taken
      if (take) begin
        last_r <= head_last;
      end
      if (start) begin
        src_r <= i_req_src;
        o_xfer_direction <= i_req_write;
        o_write_not_read <= i_req_write;
        o_data_not_code  <= i_req_data;
        o_lock_n <= ~i_req_atomic;
      end
      // Selects from address to last data
      if (state_nxt == `ST_ADDR || state_nxt == `ST_DATA) begin
        o_byte_lane_sel_n <= sel_n;
      end else begin
        o_byte_lane_sel_n <= `BE_IDLE_N;
      end
      // Strobe spans data cycles; direction is stable meanwhile
      o_data_phase_strobe_n <= ~(state_nxt == `ST_DATA);
      if (beat_ok & last_r) begin
        o_lock_n <= 1'b1;
      end
    end else if (float_all) begin
      o_ctl_oe           <= 1'b0;
      o_byte_lane_sel_oe <= 1'b0;
      o_clocks_stopped   <= 1'b1;
    end
  end
endmodule

// >>> testbench/lbus_ctl_props.sv
`timescale 1ns/1ps
module lbus_ctl_props (
  input logic       i_sys_clk,
  input logic       i_resetn,
  input logic       i_int_mem_ctl,
  input logic       i_ext_ready_recover_n,
  input logic [3:0] o_byte_lane_sel_n,
  input logic       o_byte_lane_sel_oe,
  input logic       o_data_phase_strobe_n,
  input logic       o_xfer_direction,
  input logic       o_write_not_read,
  input logic       o_data_not_code,
  input logic       o_lock_n,
  input logic       o_ctl_oe,
  input logic       o_bus_hold_ack,
  input logic       o_core_in_reset,
  input logic       o_clocks_stopped,
  input logic       o_access_done
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // Two data clocks in a row, so the previous value is from the same access
  sequence s_data2;
    !o_data_phase_strobe_n ##1 !o_data_phase_strobe_n;
  endsequence
  sequence s_ext_wait;
    !o_data_phase_strobe_n && !i_int_mem_ctl && i_ext_ready_recover_n;
  endsequence
  a_dir_no_toggle: assert property (s_data2 |-> $stable(o_xfer_direction))
    else $error("direction moved in data");
  a_kind_latched: assert property (s_data2 |-> $stable({o_write_not_read, o_data_not_code}))
    else $error("kind moved in data");
  a_dir_follows_kind: assert property (!o_data_phase_strobe_n |-> o_xfer_direction == o_write_not_read)
    else $error("direction not kind");
  a_sel_from_addr: assert property ($fell(o_data_phase_strobe_n) |-> $stable(o_byte_lane_sel_n))
    else $error("lanes moved into data");
  a_sel_driven: assert property (!o_data_phase_strobe_n |-> o_byte_lane_sel_oe)
    else $error("lanes not driven");
  a_wait_extends: assert property (s_ext_wait |=> !o_data_phase_strobe_n && !o_access_done)
    else $error("wait not inserted");
  a_done_idle: assert property (o_access_done |-> o_data_phase_strobe_n && o_lock_n && o_byte_lane_sel_n == 4'hf)
    else $error("outputs active after end");
  a_no_hold_lock: assert property (!o_lock_n |-> !o_bus_hold_ack)
    else $error("hold during lock");
  a_hold_floats: assert property (o_bus_hold_ack || o_clocks_stopped |-> !o_ctl_oe && !o_byte_lane_sel_oe)
    else $error("bus driven while released");
  a_recov_no_addr: assert property (o_data_phase_strobe_n && o_byte_lane_sel_n == 4'hf && !i_int_mem_ctl && !i_ext_ready_recover_n |=> o_byte_lane_sel_n == 4'hf)
    else $error("address during recovery");
  a_held_core_quiet: assert property (o_core_in_reset |-> o_data_phase_strobe_n)
    else $error("access while core held");
endmodule
bind local_bus_master_control lbus_ctl_props lbus_ctl_props_inst (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_int_mem_ctl(i_int_mem_ctl),
  .i_ext_ready_recover_n(i_ext_ready_recover_n), .o_byte_lane_sel_n(o_byte_lane_sel_n),
  .o_byte_lane_sel_oe(o_byte_lane_sel_oe), .o_data_phase_strobe_n(o_data_phase_strobe_n),
  .o_xfer_direction(o_xfer_direction), .o_write_not_read(o_write_not_read),
  .o_data_not_code(o_data_not_code), .o_lock_n(o_lock_n), .o_ctl_oe(o_ctl_oe),
  .o_bus_hold_ack(o_bus_hold_ack), .o_core_in_reset(o_core_in_reset),
  .o_clocks_stopped(o_clocks_stopped), .o_access_done(o_access_done));

// >>> testbench/ext_mem_model.sv
`timescale 1ns/1ps
// Far-side controller: stalls each beat, then two recovery clocks
module ext_mem_model (
  input  wire       i_clk,
  input  wire       i_strobe_n,
  input  wire [3:0] i_waits,
  output reg        o_ready_n
);
  reg [3:0] cnt_r = 4'h0;
  reg       rec_r = 1'b0;
  initial o_ready_n = 1'b1;
  // wait and recovery stalls, pull-up level when idle
  always @(posedge i_clk) begin
    #1;
    if (!i_strobe_n) begin
      o_ready_n = (cnt_r != i_waits);
      cnt_r = o_ready_n ? cnt_r + 4'h1 : 4'h0;
      rec_r = 1'b1;
    end else if (rec_r && cnt_r < 4'h2) begin
      o_ready_n = 1'b0;
      cnt_r = cnt_r + 4'h1;
    end else begin
      o_ready_n = 1'b1;
      rec_r = 1'b0;
      cnt_r = 4'h0;
    end
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "lbus_ctl_consts.vh"
module tb;
  logic       clk = 0, rstn = 0, bv = 0, last = 0, wr = 1, dat = 1, atom = 0, seen;
  logic       imc = 0, irdy_n = 1, hreq = 0, prst_n = 0, chs = 1, fam_n = 1, bws = 0, crc = 0;
  logic [3:0] be = 4'hf, waits = 4'h0, sels [0:7];
  logic [1:0] wid = `WIDTH_32, src = `SRC_CORE, adr = 2'h0;
  wire  [3:0] sel_n;
  wire        brdy, sel_oe, stb_n, dir, wnr, dnc, lock_n, ctl_oe, hack, lrr_n;
  wire        cir, cstop, pvs, done, erdy_n;
  int         err_count = 0, cmp_count = 0, nb;
  always #5 clk = ~clk;
  local_bus_master_control local_bus_master_control_inst (
    .i_sys_clk(clk), .i_resetn(rstn), .i_ce(1'b1), .i_beat_valid(bv), .o_beat_ready(brdy),
    .i_beat_be(be), .i_beat_last(last), .i_region_width(wid), .i_req_src(src),
    .i_start_addr(adr), .i_req_write(wr), .i_req_data(dat), .i_req_atomic(atom),
    .i_int_mem_ctl(imc), .i_internal_ready_n(irdy_n), .i_ext_ready_recover_n(erdy_n),
    .i_hold_req(hreq), .i_pci_rst_n(prst_n), .i_core_hold_strap(chs),
    .i_float_all_mode_n(fam_n), .i_bus_width_retry_strap(bws), .i_core_reset_clear(crc),
    .o_byte_lane_sel_n(sel_n), .o_byte_lane_sel_oe(sel_oe), .o_data_phase_strobe_n(stb_n),
    .o_xfer_direction(dir), .o_write_not_read(wnr), .o_data_not_code(dnc),
    .o_lock_n(lock_n), .o_ctl_oe(ctl_oe), .o_bus_hold_ack(hack),
    .o_local_ready_recover_out_n(lrr_n), .o_core_in_reset(cir), .o_clocks_stopped(cstop),
    .o_periph_via_secondary(pvs), .o_access_done(done));
  ext_mem_model ext_mem_model_inst (
    .i_clk(clk), .i_strobe_n(stb_n), .i_waits(waits), .o_ready_n(erdy_n));
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: %s", $time, m);
    end
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // Pushes n beats and records the lanes of every beat that completes
  task acc(input int n, input logic [3:0] b0, input logic [3:0] b1);
    int i, k;
    nb = 0;
    seen = 0;
    fork
      begin
        for (i = 0; i < n; i++) begin
          bv = 1;
          be = i ? b1 : b0;
          last = (i == n - 1);
          tick;
        end
        bv = 0;
      end
      for (k = 0; k < 300 && !seen; k++) begin
        @(negedge clk);
        seen = done;
        if (!stb_n) begin
          chk(dir, wr, "direction");
          chk(dnc, dat, "data or code");
          chk(wnr, wr, "write flag");
          chk(lock_n, !atom, "lock level");
          if (!(imc ? irdy_n : erdy_n)) begin
            sels[nb] = sel_n;
            nb++;
          end
        end
      end
    join
    if (!seen) begin
      chk(seen, 1, "access timeout");
      test_done;
    end
    tick;
  endtask
  task t_widths;
    adr = 2'h2;
    acc(1, 4'h5, 4'h0);
    chk(sels[0], 4'ha, "32-bit lanes");
    wid = `WIDTH_16;
    acc(1, 4'hf, 4'h0);
    chk(sels[0], 4'h6, "16-bit lanes");
    wid = `WIDTH_8;
    wr = 0;
    dat = 0;
    acc(1, 4'hf, 4'h0);
    chk(sels[0], 4'he, "8-bit lanes");
    wr = 1;
    dat = 1;
    $display("t_widths done");
  endtask
  task t_burst;
    int i;
    adr = 2'h1;
    waits = 4'h1;
    acc(4, 4'hf, 4'hf);
    chk(4'(nb), 4'h4, "beat count");
    for (i = 0; i < 4; i++) chk(sels[i], {2'b11, 2'(adr + i)}, "address on lanes");
    $display("t_burst done");
  endtask
  task t_src;
    int s;
    wid = `WIDTH_32;
    waits = 4'h0;
    for (s = 0; s < 3; s++) begin
      src = 2'(s);
      acc(2, 4'h3, 4'hc);
      chk(sels[1], s ? 4'h3 : 4'hc, "second beat lanes");
    end
    $display("t_src done");
  endtask
  task t_lock;
    int i;
    atom = 1;
    waits = 4'h3;
    fork
      acc(2, 4'hf, 4'hf);
      begin
        repeat (5) tick;
        hreq = 1;
      end
    join
    atom = 0;
    for (i = 0; i < 20 && hack !== 1'b1; i++) tick;
    chk(hack, 1, "hold granted");
    if (hack !== 1'b1) test_done;
    chk({sel_oe, ctl_oe}, 0, "bus floated");
    hreq = 0;
    for (i = 0; i < 20 && hack !== 1'b0; i++) tick;
    chk(hack, 0, "hold dropped");
    if (hack !== 1'b0) test_done;
    $display("t_lock done");
  endtask
  // Held core lets the FIFO fill; releasing it drains every queued access
  task t_core;
    int i, n;
    logic lo;
    prst_n = 0;
    chs = 0;
    bws = 1;
    repeat (4) tick;
    prst_n = 1;
    repeat (3) tick;
    chk(cir, 1, "core held");
    chk(pvs, 1, "peripheral route");
    bv = 1;
    last = 1;
    repeat (8) tick;
    bv = 0;
    repeat (2) tick;
    chk(brdy, 0, "fifo full");
    imc = 1;
    irdy_n = 0;
    crc = 1;
    tick;
    crc = 0;
    n = 0;
    lo = 1;
    for (i = 0; i < 400 && n < 8; i++) begin
      @(negedge clk);
      n += done;
      lo &= lrr_n;
    end
    tick;
    chk(4'(n), 4'h8, "queued accesses");
    if (n < 8) test_done;
    chk(lo, 0, "local ready copy");
    chk(brdy, 1, "fifo drained");
    $display("t_core done");
  endtask
  task t_float;
    prst_n = 0;
    fam_n = 0;
    repeat (4) tick;
    prst_n = 1;
    repeat (3) tick;
    chk(cstop, 1, "clocks stopped");
    chk({sel_oe, ctl_oe}, 0, "outputs floated");
    $display("t_float done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rstn = 1;
    repeat (3) tick;
    prst_n = 1;
    repeat (4) tick;
    t_widths;
    t_burst;
    t_src;
    t_lock;
    t_core;
    t_float;
    test_done;
  end
endmodule
